// ### btcu_pkg.sv
// shared types and constants of the bit and type conversion unit
package btcu_pkg;
  // device memory geometry
  localparam int unsigned MEM_WORDS = 1024;
  localparam logic [15:0] BIT_SPAN  = 16'h4000;
  localparam logic [10:0] WORD_SPAN = 11'h400;
  // timer and counter presets sit above their current values
  localparam logic [10:0] TC_PRESET_OFS = 11'h200;
  // operand limits
  localparam logic [15:0] POP_QTY_MAX = 16'h0100;
  localparam logic [15:0] DEC_OFS_MAX = 16'h00ff;
  localparam logic [6:0]  REP_MAX     = 7'h63;
  // float fields
  localparam logic [7:0] F_BIAS    = 8'h7f;
  localparam logic [7:0] F_EXP_SAT = 8'ha0;
  localparam logic [7:0] F_EXP_ALL = 8'hff;
  // saturation bounds of the integer types, and the magnitude that huge floats are pinned to
  localparam logic signed [39:0] IV_ZERO    = 40'sh00_0000_0000;
  localparam logic signed [39:0] IV_U16_MAX = 40'sh00_0000_ffff;
  localparam logic signed [39:0] IV_S16_MIN = 40'shff_ffff_8000;
  localparam logic signed [39:0] IV_S16_MAX = 40'sh00_0000_7fff;
  localparam logic signed [39:0] IV_U32_MAX = 40'sh00_ffff_ffff;
  localparam logic signed [39:0] IV_S32_MIN = 40'shff_8000_0000;
  localparam logic signed [39:0] IV_S32_MAX = 40'sh00_7fff_ffff;
  localparam logic [39:0]        IV_BIG     = 40'h10_0000_0000;

  typedef enum logic [2:0] {
    OP_NONE    = 3'b000,
    OP_POPCNT  = 3'b001,
    OP_TOGGLE  = 3'b010,
    OP_CONVERT = 3'b011,
    OP_SPLIT   = 3'b100,
    OP_DECODE  = 3'b101
  } btcu_op_t;

  typedef enum logic [1:0] {
    K_BIT    = 2'b00,
    K_DATA   = 2'b01,
    K_TIMCNT = 2'b10,
    K_CONST  = 2'b11
  } btcu_kind_t;

  typedef enum logic [2:0] {
    T_WORD  = 3'b000,
    T_INT   = 3'b001,
    T_DWORD = 3'b010,
    T_LONG  = 3'b011,
    T_FLOAT = 3'b100
  } btcu_type_t;

  typedef struct packed {
    btcu_kind_t  kind;
    logic [13:0] addr;
  } btcu_opnd_t;

  typedef struct packed {
    btcu_op_t    op;
    btcu_opnd_t  src1;
    btcu_opnd_t  src2;
    btcu_opnd_t  dst;
    btcu_type_t  styp;
    btcu_type_t  dtyp;
    logic [6:0]  rep;
    logic [31:0] cval;
  } btcu_cmd_t;

  typedef struct packed {
    logic        we;
    logic [9:0]  addr;
    logic [15:0] data;
  } btcu_wr_t;
endpackage

// ### btcu_mem.sv
// device memory: one write port, one registered read port
`timescale 1ns/1ps
module btcu_mem #(
  parameter int unsigned WORDS = 1024,
  parameter int unsigned AW    = 10,
  parameter int unsigned DW    = 16
) (
  // clock and reset
  input  wire logic          clock_i,
  input  wire logic          rst_n_i,
  // write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  // read port
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_q [WORDS];

  // storage write
  always_ff @(posedge clock_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  // registered read
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem_q[raddr_i];
    end
  end
endmodule

// ### btcu_unit.sv
// bit count, toggle, type convert, byte split and bit decode execution unit
`timescale 1ns/1ps
module btcu_unit (
  // clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  // scan sequencer
  input  wire logic                 scan_start_i,
  input  wire logic                 exec_i,
  input  wire btcu_pkg::btcu_cmd_t  cmd_i,
  input  wire logic                 err_clr_i,
  // host access to device memory
  input  wire btcu_pkg::btcu_wr_t   host_wr_i,
  input  wire logic [9:0]           host_raddr_i,
  output logic      [15:0]          host_rdata_o,
  // status
  output logic                      busy_o,
  output logic                      done_o,
  output logic                      exec_err_o,
  output logic                      exec_error_flag_o,
  output logic                      error_lamp_o
);
  import btcu_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_PRD  = 4'h1,
    S_PRW  = 4'h2,
    S_CHK  = 4'h3,
    S_RD   = 4'h4,
    S_RW   = 4'h5,
    S_CV   = 4'h6,
    S_WR   = 4'h7,
    S_DONE = 4'h8
  } btcu_state_t;

  function automatic logic [9:0] word_of(input btcu_opnd_t o);
    word_of = (o.kind == K_BIT) ? o.addr[13:4] : o.addr[9:0];
  endfunction

  function automatic logic wide_t(input btcu_type_t t);
    wide_t = (t == T_DWORD) || (t == T_LONG) || (t == T_FLOAT);
  endfunction

  function automatic logic [4:0] pop16(input logic [15:0] w);
    pop16 = 5'h0;
    for (int i = 0; i < 16; i++) begin
      pop16 = pop16 + {4'h0, w[i]};
    end
  endfunction

  function automatic logic signed [39:0] clampv(input logic signed [39:0] v, lo, hi);
    clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // float to integer, fraction dropped, huge values pinned
  function automatic logic signed [39:0] f2i(input logic [31:0] f);
    logic [63:0] m;
    logic [39:0] mag;
    m = 64'h0;
    if (f[30:23] < F_BIAS) begin
      mag = 40'h0;
    end else if (f[30:23] > F_EXP_SAT) begin
      mag = IV_BIG;
    end else begin
      m = {40'h0, 1'b1, f[22:0]} << (f[30:23] - F_BIAS);
      mag = m[62:23];
    end
    f2i = f[31] ? -$signed(mag) : $signed(mag);
  endfunction

  // integer to float, mantissa truncated
  function automatic logic [31:0] i2f(input logic signed [39:0] v);
    logic [39:0] mag;
    logic [63:0] t;
    logic [5:0]  p;
    mag = v[39] ? 40'(-v) : 40'(v);
    p = 6'h0;
    for (int i = 0; i < 40; i++) begin
      if (mag[i]) begin
        p = 6'(i);
      end
    end
    t = {24'h0, mag} << (6'h3f - p);
    i2f = (mag == 40'h0) ? 32'h0 : {v[39], 8'({2'b00, p}) + F_BIAS, t[62:40]};
  endfunction

  btcu_state_t st_q;
  btcu_cmd_t   cmd_q;
  logic [15:0] par_q;
  logic [9:0]  ra_q;
  logic [9:0]  wa_q;
  logic [13:0] bp_q;
  logic [8:0]  left_q;
  logic [8:0]  acc_q;
  logic [31:0] src_q;
  logic [31:0] res_q;
  logic [1:0]  wrn_q;
  logic [6:0]  rep_q;
  logic        rdn_q;
  logic        acc_scan_q;
  logic [15:0] mem_rdata;

  // request acceptance, one per scan
  wire btcu_opnd_t psel   = (cmd_i.op == OP_DECODE) ? cmd_i.src1 : cmd_i.src2;
  wire logic       idle   = (st_q == S_IDLE);
  wire logic       accept = idle && exec_i && (cmd_i.op != OP_NONE) && (!acc_scan_q || scan_start_i);
  wire logic       needp  = (cmd_i.op == OP_POPCNT) || (cmd_i.op == OP_DECODE);

  // operand checks
  wire logic        dconst  = (cmd_q.dst.kind == K_CONST);
  wire logic [15:0] pop_end = {2'b00, cmd_q.src1.addr} + par_q;
  wire logic [15:0] dec_bit = {2'b00, cmd_q.dst.addr} + {8'h00, par_q[7:0]};
  wire logic        pop_err = (par_q == 16'h0) || (par_q > POP_QTY_MAX) || (pop_end > BIT_SPAN)
                              || cmd_q.src1.kind[1] || dconst;
  wire logic        dec_err = (par_q > DEC_OFS_MAX) || (dec_bit >= BIT_SPAN) || cmd_q.dst.kind[1];
  wire logic        tog_err = (cmd_q.dst.kind != K_BIT);
  wire logic [9:0]  dw0     = word_of(cmd_q.dst);
  wire logic        spl_err = (cmd_q.dst.kind != K_DATA) || (dw0 == 10'h3ff);
  wire logic [10:0] tcofs   = (cmd_q.dst.kind == K_TIMCNT) ? TC_PRESET_OFS : 11'h0;
  wire logic [10:0] dbase   = {1'b0, dw0} + tcofs;
  wire logic [10:0] srep    = wide_t(cmd_q.styp) ? {3'b000, cmd_q.rep, 1'b0} : {4'h0, cmd_q.rep};
  wire logic [10:0] drep    = wide_t(cmd_q.dtyp) ? {3'b000, cmd_q.rep, 1'b0} : {4'h0, cmd_q.rep};
  wire logic        cv_rng  = ((cmd_q.src1.kind != K_CONST) && ({1'b0, word_of(cmd_q.src1)} + srep > WORD_SPAN))
                              || (dbase + drep > WORD_SPAN);
  wire logic        cv_flt  = ((cmd_q.styp == T_FLOAT) && !(cmd_q.src1.kind inside {K_DATA, K_CONST}))
                              || ((cmd_q.dtyp == T_FLOAT) && (cmd_q.dst.kind != K_DATA));
  wire logic        cv_err  = (cmd_q.rep == 7'h0) || (cmd_q.rep > REP_MAX) || cv_rng || cv_flt || dconst
                              || (cmd_q.styp > T_FLOAT) || (cmd_q.dtyp > T_FLOAT);
  logic chk_err;
  always_comb begin
    case (cmd_q.op)
      OP_POPCNT:  chk_err = pop_err;
      OP_DECODE:  chk_err = dec_err;
      OP_TOGGLE:  chk_err = tog_err;
      OP_SPLIT:   chk_err = spl_err;
      OP_CONVERT: chk_err = cv_err;
      default:    chk_err = 1'b1;
    endcase
  end

  // population count step over one word
  wire logic [4:0]  avail = 5'h10 - {1'b0, bp_q[3:0]};
  wire logic [4:0]  nbits = (left_q < {4'h0, avail}) ? left_q[4:0] : avail;
  wire logic [16:0] nmask = (17'h1 << nbits) - 17'h1;
  wire logic [4:0]  wcnt  = pop16((mem_rdata >> bp_q[3:0]) & nmask[15:0]);
  wire logic [15:0] bmask = 16'h1 << bp_q[3:0];

  // type conversion
  wire btcu_type_t dt_eff = (cmd_q.dst.kind == K_TIMCNT) ? T_WORD : cmd_q.dtyp;
  wire logic       fnorm  = ((src_q[30:23] != 8'h0) && (src_q[30:23] != F_EXP_ALL)) || (src_q[30:0] == 31'h0);
  wire logic       cv_bad = (cmd_q.styp == T_FLOAT) && !fnorm;
  logic signed [39:0] iv;
  logic [31:0]        cvv;
  always_comb begin
    case (cmd_q.styp)
      T_WORD:  iv = {24'h0, src_q[15:0]};
      T_INT:   iv = {{24{src_q[15]}}, src_q[15:0]};
      T_DWORD: iv = {8'h0, src_q};
      T_LONG:  iv = {{8{src_q[31]}}, src_q};
      default: iv = f2i(src_q);
    endcase
    case (dt_eff)
      T_WORD:  cvv = {16'h0, 16'(clampv(iv, IV_ZERO, IV_U16_MAX))};
      T_INT:   cvv = {16'h0, 16'(clampv(iv, IV_S16_MIN, IV_S16_MAX))};
      T_DWORD: cvv = 32'(clampv(iv, IV_ZERO, IV_U32_MAX));
      T_LONG:  cvv = 32'(clampv(iv, IV_S32_MIN, IV_S32_MAX));
      default: cvv = i2f(iv);
    endcase
  end
  wire logic [31:0] cv_res = (cmd_q.styp == dt_eff) ? src_q : cvv;

  // memory port sharing, host only while idle
  wire logic        wr_en  = (st_q == S_WR);
  wire logic [15:0] mem_wd = (wrn_q == 2'd2) ? res_q[31:16] : res_q[15:0];
  wire logic        m_we   = wr_en || (host_wr_i.we && idle);
  wire logic [9:0]  m_wa   = wr_en ? wa_q : host_wr_i.addr;
  wire logic [15:0] m_wd   = wr_en ? mem_wd : host_wr_i.data;
  wire logic [9:0]  m_ra   = idle ? host_raddr_i : ra_q;
  wire logic        err_ev = ((st_q == S_CHK) && chk_err) || ((st_q == S_CV) && cv_bad);
  assign host_rdata_o = mem_rdata;

  btcu_mem #(.WORDS(MEM_WORDS), .AW(10), .DW(16)) u_mem (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .we_i    (m_we),
    .waddr_i (m_wa),
    .wdata_i (m_wd),
    .raddr_i (m_ra),
    .rdata_o (mem_rdata)
  );

  // status flops, error flag set wins over clear
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_scan_q        <= 1'b0;
      exec_error_flag_o <= 1'b0;
      error_lamp_o      <= 1'b0;
      busy_o            <= 1'b0;
      done_o            <= 1'b0;
    end else begin
      acc_scan_q        <= accept || (acc_scan_q && !scan_start_i);
      exec_error_flag_o <= err_ev || (exec_error_flag_o && !err_clr_i);
      error_lamp_o      <= err_ev || (error_lamp_o && !err_clr_i);
      busy_o            <= accept || (!idle && (st_q != S_DONE));
      done_o            <= (st_q == S_DONE);
    end
  end

  // instruction sequencer
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= S_IDLE;
      cmd_q <= '0;
      par_q <= '0;
      ra_q <= '0;
      wa_q <= '0;
      bp_q <= '0;
      left_q <= '0;
      acc_q <= '0;
      src_q <= '0;
      res_q <= '0;
      wrn_q <= '0;
      rep_q <= '0;
      rdn_q <= 1'b0;
      exec_err_o <= 1'b0;
    end else begin
      case (st_q)
        S_IDLE: begin
          exec_err_o <= 1'b0;
          if (accept) begin
            cmd_q <= cmd_i;
            par_q <= cmd_i.cval[15:0];
            ra_q  <= word_of(psel);
            st_q  <= (needp && (psel.kind != K_CONST)) ? S_PRD : S_CHK;
          end
        end
        S_PRD: st_q <= S_PRW;
        S_PRW: begin
          par_q <= mem_rdata;
          st_q  <= S_CHK;
        end
        S_CHK: begin
          wa_q  <= dbase[9:0];
          rep_q <= cmd_q.rep;
          src_q <= cmd_q.cval;
          rdn_q <= wide_t(cmd_q.styp);
          ra_q  <= word_of(cmd_q.src1);
          if (chk_err) begin
            exec_err_o <= 1'b1;
            st_q <= S_DONE;
          end else begin
            case (cmd_q.op)
              OP_POPCNT: begin
                bp_q   <= cmd_q.src1.addr;
                ra_q   <= cmd_q.src1.addr[13:4];
                left_q <= par_q[8:0];
                acc_q  <= '0;
                st_q   <= S_RD;
              end
              OP_TOGGLE: begin
                bp_q <= cmd_q.dst.addr;
                ra_q <= cmd_q.dst.addr[13:4];
                st_q <= S_RD;
              end
              OP_DECODE: begin
                bp_q <= dec_bit[13:0];
                ra_q <= dec_bit[13:4];
                st_q <= S_RD;
              end
              default: st_q <= (cmd_q.src1.kind == K_CONST) ? ((cmd_q.op == OP_SPLIT) ? S_RW : S_CV) : S_RD;
            endcase
          end
        end
        S_RD: st_q <= S_RW;
        S_RW: begin
          case (cmd_q.op)
            OP_POPCNT: begin
              acc_q  <= acc_q + {4'h0, wcnt};
              left_q <= left_q - {4'h0, nbits};
              bp_q   <= bp_q + {9'h0, nbits};
              ra_q   <= ra_q + 10'h1;
              res_q  <= {23'h0, acc_q + {4'h0, wcnt}};
              wrn_q  <= 2'd1;
              st_q   <= (left_q == {4'h0, nbits}) ? S_WR : S_RD;
            end
            OP_TOGGLE: begin
              res_q <= {16'h0, mem_rdata ^ bmask};
              wa_q  <= ra_q;
              wrn_q <= 2'd1;
              st_q  <= S_WR;
            end
            OP_DECODE: begin
              res_q <= {16'h0, mem_rdata | bmask};
              wa_q  <= ra_q;
              wrn_q <= 2'd1;
              st_q  <= S_WR;
            end
            OP_SPLIT: begin
              if (cmd_q.src1.kind == K_CONST) begin
                res_q <= {8'h00, cmd_q.cval[15:8], 8'h00, cmd_q.cval[7:0]};
              end else begin
                res_q <= {8'h00, mem_rdata[15:8], 8'h00, mem_rdata[7:0]};
              end
              wrn_q <= 2'd2;
              st_q  <= S_WR;
            end
            default: begin
              ra_q  <= ra_q + 10'h1;
              rdn_q <= 1'b0;
              if (rdn_q) begin
                src_q[31:16] <= mem_rdata;
                st_q <= S_RD;
              end else begin
                src_q[15:0] <= mem_rdata;
                st_q <= S_CV;
              end
            end
          endcase
        end
        S_CV: begin
          res_q <= cv_res;
          wrn_q <= wide_t(dt_eff) ? 2'd2 : 2'd1;
          if (cv_bad) begin
            exec_err_o <= 1'b1;
            st_q <= S_DONE;
          end else begin
            st_q <= S_WR;
          end
        end
        S_WR: begin
          wrn_q <= wrn_q - 2'd1;
          wa_q  <= wa_q + 10'h1;
          if (wrn_q == 2'd1) begin
            if ((cmd_q.op == OP_CONVERT) && (rep_q > 7'h1)) begin
              rep_q <= rep_q - 7'h1;
              rdn_q <= wide_t(cmd_q.styp);
              if ((cmd_q.dst.kind == K_TIMCNT) && wide_t(cmd_q.dtyp)) begin
                wa_q <= wa_q + 10'h2;
              end
              st_q <= (cmd_q.src1.kind == K_CONST) ? S_CV : S_RD;
            end else begin
              st_q <= S_DONE;
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_reject;
    (st_q == S_DONE) ##1 (done_o && exec_err_o && exec_error_flag_o);
  endsequence

  qty_reject_a: assert property ((st_q == S_CHK) && (cmd_q.op == OP_POPCNT) && ((par_q == 16'h0) || (par_q > POP_QTY_MAX)) |=> s_reject) else $error("bad bit quantity accepted");
  dec_reject_a: assert property ((st_q == S_CHK) && (cmd_q.op == OP_DECODE) && (par_q > DEC_OFS_MAX) |=> s_reject) else $error("bad decode offset accepted");
  float_kind_a: assert property ((st_q == S_CHK) && (cmd_q.op == OP_CONVERT) && cv_flt |=> s_reject) else $error("float operand kind accepted");
  float_norm_a: assert property ((st_q == S_CV) && cv_bad |=> s_reject) else $error("abnormal float accepted");
  split_dst_a: assert property ((st_q == S_CHK) && (cmd_q.op == OP_SPLIT) && (cmd_q.dst.kind != K_DATA) |=> s_reject) else $error("split destination accepted");
  toggle_inv_a: assert property (wr_en && (cmd_q.op == OP_TOGGLE) |-> ((mem_wd ^ $past(mem_rdata)) == bmask)) else $error("toggle did not invert one bit");
  decode_set_a: assert property (wr_en && (cmd_q.op == OP_DECODE) |-> (mem_wd == ($past(mem_rdata) | bmask))) else $error("decode bit not set");
  split_bytes_a: assert property ((st_q == S_RW) && (cmd_q.op == OP_SPLIT) && (cmd_q.src1.kind != K_CONST) |=> (wr_en && (mem_wd == {8'h00, $past(mem_rdata[15:8])})) ##1 (wr_en && (mem_wd == {8'h00, $past(mem_rdata[7:0], 2)}))) else $error("split bytes wrong");
  same_type_a: assert property ((st_q == S_CV) && (cmd_q.styp == dt_eff) && !cv_bad |=> (res_q == $past(src_q))) else $error("same type not copied");
  sat_word_a: assert property ((st_q == S_CV) && (dt_eff == T_WORD) && (iv > IV_U16_MAX) |=> (res_q[15:0] == 16'hffff)) else $error("word not saturated");
  one_scan_a: assert property (idle && acc_scan_q && !scan_start_i |=> (st_q == S_IDLE) && !busy_o)
    else $error("second execution in scan");
  done_bound_a: assert property (accept |-> ##[3:1000] done_o) else $error("instruction never finished");
endmodule

// ### btcu_seq_model.sv
// scan sequencer model: scan pulses and one-cycle enabling strobes
`timescale 1ns/1ps
module btcu_seq_model (
  // clock
  input  wire logic           clock_i,
  // status from the unit
  input  wire logic           done_i,
  input  wire logic           exec_err_i,
  // strobes to the unit
  output logic                scan_start_o,
  output logic                exec_o,
  output btcu_pkg::btcu_cmd_t cmd_o
);
  import btcu_pkg::*;

  // idle levels at time zero
  initial begin
    scan_start_o = 1'b0;
    exec_o = 1'b0;
    cmd_o = '0;
  end

  // one enabling pulse, optional new scan, bounded wait for done
  task automatic issue(input btcu_cmd_t c, input logic new_scan, output logic seen, output logic err);
    int n;
    @(negedge clock_i);
    scan_start_o = new_scan;
    exec_o = 1'b1; // one-cycle pulse per scan
    cmd_o = c;
    @(negedge clock_i);
    scan_start_o = 1'b0;
    exec_o = 1'b0;
    cmd_o = ~c; // stale command must not matter after accept
    seen = 1'b0;
    err = 1'b0;
    for (n = 0; n < 1000 && !seen; n++) begin
      @(posedge clock_i);
      #1;
      if (done_i === 1'b1) begin
        seen = 1'b1;
        err = exec_err_i;
      end
    end
  endtask
endmodule

// ### btcu_tb_top.sv
// self-checking testbench of the bit and type conversion unit
`timescale 1ns/1ps
module bit_and_type_conversion_unit_tb_top;
  import btcu_pkg::*;
  logic        clock_i, rst_n_i, scan_start, exec, err_clr;
  btcu_cmd_t   cmd;
  btcu_wr_t    host_wr;
  logic [9:0]  host_raddr;
  logic [15:0] host_rdata, rd_d;
  logic        busy, done, exec_err, flag, lamp, seen, err;
  int          mismatches, tests_run, cycles, busy_cycles;

  btcu_unit u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .scan_start_i(scan_start), .exec_i(exec),
    .cmd_i(cmd), .err_clr_i(err_clr), .host_wr_i(host_wr), .host_raddr_i(host_raddr),
    .host_rdata_o(host_rdata), .busy_o(busy), .done_o(done), .exec_err_o(exec_err),
    .exec_error_flag_o(flag), .error_lamp_o(lamp));
  btcu_seq_model u_seq (.clock_i(clock_i), .done_i(done), .exec_err_i(exec_err),
    .scan_start_o(scan_start), .exec_o(exec), .cmd_o(cmd));

  // clock and hang guard
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (busy === 1'b1) begin
      busy_cycles++;
    end
    if (cycles == 30000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (mismatches == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // compares
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t word got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t status got %b exp %b", $time, got, exp);
    end
  endtask

  // host memory access, only while idle
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(negedge clock_i);
    host_wr = '{we: 1'b1, addr: a, data: d};
    @(negedge clock_i);
    host_wr.we = 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, output logic [15:0] d);
    @(negedge clock_i);
    host_raddr = a;
    @(posedge clock_i);
    #1;
    d = host_rdata;
  endtask

  function automatic btcu_cmd_t mk(btcu_op_t op, btcu_kind_t k1, logic [13:0] a1, btcu_kind_t k2,
    logic [13:0] a2, btcu_kind_t kd, logic [13:0] ad, btcu_type_t st, btcu_type_t dt, logic [31:0] cv);
    mk = '{op: op, src1: '{k1, a1}, src2: '{k2, a2}, dst: '{kd, ad}, styp: st, dtyp: dt, rep: 7'h01, cval: cv};
  endfunction

  // accepted instruction, then one result word
  task automatic ok_word(input btcu_cmd_t c, input logic [9:0] a, input logic [15:0] e);
    logic [15:0] d;
    int          b0;
    b0 = busy_cycles;
    u_seq.issue(c, 1'b1, seen, err);
    chk1(seen, 1'b1);
    chk1(err, 1'b0);
    chk1(busy_cycles > b0, 1'b1);
    chk1(busy, 1'b0);
    rd(a, d);
    chk16(d, e);
  endtask
  // rejected instruction: error, flag and lamp, then cleared
  task automatic bad(input btcu_cmd_t c);
    u_seq.issue(c, 1'b1, seen, err);
    chk1(seen, 1'b1);
    chk1(err, 1'b1);
    chk1(flag, 1'b1);
    chk1(lamp, 1'b1);
    @(negedge clock_i);
    err_clr = 1'b1;
    @(negedge clock_i);
    err_clr = 1'b0;
    @(posedge clock_i);
    #1;
    chk1(flag, 1'b0);
    chk1(lamp, 1'b0);
  endtask

  // bit count: plain run, full 256 run, timer operands, bad quantities
  task automatic t_popcount();
    wr(10'h010, 16'h00ff);
    wr(10'h011, 16'h0003);
    for (int i = 2; i < 16; i++) wr(10'h010 + 10'(i), 16'h0000);
    wr(10'h031, 16'h0009);
    ok_word(mk(OP_POPCNT, K_DATA, 14'h0100, K_CONST, 0, K_DATA, 14'h0020, T_WORD, T_WORD, 20), 10'h020, 16'd10);
    ok_word(mk(OP_POPCNT, K_DATA, 14'h0100, K_CONST, 0, K_DATA, 14'h0021, T_WORD, T_WORD, 256), 10'h021, 16'd10);
    ok_word(mk(OP_POPCNT, K_DATA, 14'h0100, K_TIMCNT, 14'h0031, K_TIMCNT, 14'h0030, T_WORD, T_WORD, 0), 10'h230, 16'd8);
    ok_word(mk(OP_POPCNT, K_DATA, 14'h0100, K_CONST, 0, K_DATA, 14'h0020, T_WORD, T_WORD, 4), 10'h020, 16'd4);
    bad(mk(OP_POPCNT, K_DATA, 14'h0100, K_CONST, 0, K_DATA, 14'h0022, T_WORD, T_WORD, 0));
    bad(mk(OP_POPCNT, K_DATA, 14'h0100, K_CONST, 0, K_DATA, 14'h0022, T_WORD, T_WORD, 257));
  endtask

  // toggle on three scans, then a second strobe within one scan is ignored
  task automatic t_toggle();
    btcu_cmd_t c;
    int        b0;
    c = mk(OP_TOGGLE, K_CONST, 0, K_CONST, 0, K_BIT, 14'h0405, T_WORD, T_WORD, 0);
    wr(10'h040, 16'h0000);
    ok_word(c, 10'h040, 16'h0020);
    ok_word(c, 10'h040, 16'h0000);
    ok_word(c, 10'h040, 16'h0020);
    b0 = busy_cycles;
    u_seq.issue(c, 1'b0, seen, err);
    chk1(seen, 1'b0);
    chk1(busy_cycles == b0, 1'b1);
    rd(10'h040, rd_d);
    chk16(rd_d, 16'h0020);
  endtask

  // type conversion: copy, truncation, saturation, repeat, float checks
  task automatic t_convert();
    btcu_cmd_t c;
    wr(10'h070, 16'hffff);
    wr(10'h071, 16'hffff);
    wr(10'h076, 16'h8000);
    wr(10'h07a, 16'h1111);
    wr(10'h07b, 16'h2222);
    wr(10'h07e, 16'h5a5a);
    ok_word(mk(OP_CONVERT, K_DATA, 14'h0070, K_CONST, 0, K_DATA, 14'h0072, T_DWORD, T_WORD, 0), 10'h072, 16'hffff);
    ok_word(mk(OP_CONVERT, K_DATA, 14'h0070, K_CONST, 0, K_DATA, 14'h0073, T_DWORD, T_INT, 0), 10'h073, 16'h7fff);
    ok_word(mk(OP_CONVERT, K_CONST, 0, K_CONST, 0, K_DATA, 14'h0074, T_FLOAT, T_WORD, 32'h40490fdb), 10'h074, 16'h0003);
    ok_word(mk(OP_CONVERT, K_CONST, 0, K_CONST, 0, K_DATA, 14'h0075, T_WORD, T_WORD, 32'h0000beef), 10'h075, 16'hbeef);
    ok_word(mk(OP_CONVERT, K_DATA, 14'h0076, K_CONST, 0, K_DATA, 14'h0077, T_INT, T_WORD, 0), 10'h077, 16'h0000);
    ok_word(mk(OP_CONVERT, K_DATA, 14'h0076, K_CONST, 0, K_DATA, 14'h0078, T_WORD, T_DWORD, 0), 10'h079, 16'h8000);
    ok_word(mk(OP_CONVERT, K_BIT, 14'h07e0, K_CONST, 0, K_DATA, 14'h007f, T_WORD, T_WORD, 0), 10'h07f, 16'h5a5a);
    c = mk(OP_CONVERT, K_DATA, 14'h007a, K_CONST, 0, K_DATA, 14'h007c, T_WORD, T_WORD, 0);
    c.rep = 7'h02;
    ok_word(c, 10'h07d, 16'h2222);
    ok_word(mk(OP_CONVERT, K_CONST, 0, K_CONST, 0, K_DATA, 14'h0084, T_WORD, T_FLOAT, 3), 10'h084, 16'h4040);
    ok_word(mk(OP_CONVERT, K_CONST, 0, K_CONST, 0, K_DATA, 14'h0086, T_LONG, T_INT, -131072), 10'h086, 16'h8000);
    bad(mk(OP_CONVERT, K_TIMCNT, 14'h007a, K_CONST, 0, K_DATA, 14'h0080, T_FLOAT, T_FLOAT, 0));
    bad(mk(OP_CONVERT, K_CONST, 0, K_CONST, 0, K_DATA, 14'h0080, T_FLOAT, T_WORD, 32'h7fc00000));
  endtask

  // byte split and bit decode
  task automatic t_split_decode();
    ok_word(mk(OP_SPLIT, K_CONST, 0, K_CONST, 0, K_DATA, 14'h0050, T_WORD, T_WORD, 32'h1234), 10'h050, 16'h0012);
    rd(10'h051, rd_d);
    chk16(rd_d, 16'h0034);
    bad(mk(OP_SPLIT, K_CONST, 0, K_CONST, 0, K_DATA, 14'h03ff, T_WORD, T_WORD, 32'h1234));
    bad(mk(OP_SPLIT, K_CONST, 0, K_CONST, 0, K_TIMCNT, 14'h0050, T_WORD, T_WORD, 32'h1234));
    ok_word(mk(OP_SPLIT, K_DATA, 14'h0073, K_CONST, 0, K_DATA, 14'h0052, T_WORD, T_WORD, 0), 10'h052, 16'h007f);
    rd(10'h053, rd_d);
    chk16(rd_d, 16'h00ff);
    wr(10'h062, 16'h0000);
    ok_word(mk(OP_DECODE, K_CONST, 0, K_CONST, 0, K_DATA, 14'h0600, T_WORD, T_WORD, 39), 10'h062, 16'h0080);
    bad(mk(OP_DECODE, K_CONST, 0, K_CONST, 0, K_DATA, 14'h0600, T_WORD, T_WORD, 256));
    bad(mk(OP_DECODE, K_CONST, 0, K_CONST, 0, K_DATA, 14'h3ff0, T_WORD, T_WORD, 16));
  endtask

  // main sequence
  initial begin
    rst_n_i = 1'b0;
    err_clr = 1'b0;
    host_wr = '0;
    host_raddr = '0;
    mismatches = 0;
    tests_run = 0;
    repeat (5) @(negedge clock_i);
    rst_n_i = 1'b1;
    t_popcount();
    t_toggle();
    t_convert();
    t_split_decode();
    give_verdict();
  end
endmodule
